/* rtl/rsc_pkg.sv */
// Constants for the redundancy switchover control block
package rsc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned POLL_PERIOD_MS  = 2000;
  localparam int unsigned LINK_TIMEOUT_MS = 6000;
  localparam int unsigned POLL_CYCLES     = POLL_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned TIMEOUT_CYCLES  = LINK_TIMEOUT_MS * (CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_TRIM   = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_OUTS   = 8'h0C;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTL_SWM_LSB   = 0;
  localparam int CTL_OFL_LSB   = 2;
  localparam int CTL_AREC      = 5;
  localparam int CTL_AMP       = 6;
  localparam int CTL_MUTE      = 7;
  localparam int CTL_AUX       = 8;
  localparam int CTL_LNB_LSB   = 9;
  localparam int CTL_BT        = 12;
  localparam int CTL_FORCE     = 13;

  // Status register fields
  localparam int STA_ONLINE    = 0;
  localparam int STA_LINK_UP   = 1;
  localparam int STA_LINK_LOST = 2;
  localparam int STA_FAULT     = 3;
  localparam int STA_MODE_ERR  = 4;
  localparam int STA_MISMATCH  = 5;
  localparam int STA_THROW     = 6;
  localparam int STA_PEER_FLT  = 7;

  // ----------------------------------------------------------------
  // Switch modes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] SWM_STANDALONE = 2'h0;
  localparam logic [1:0] SWM_TX         = 2'h1;
  localparam logic [1:0] SWM_TXRX       = 2'h2;
  localparam logic [1:0] RST_SWM        = 2'h0;
  localparam logic [2:0] RST_OFL        = 3'h0;
  localparam logic [2:0] RST_LNB        = 3'h0;
  localparam logic [7:0] RST_TRIM       = 8'h00;

  typedef enum logic [1:0] {
    RSC_LINK_NONE,
    RSC_LINK_UP,
    RSC_LINK_LOST
  } rsc_link_t;

endpackage

/* rtl/rsc_top.sv */
// Redundancy switchover control with AHB-Lite register slave
//
// How it works
// R1: Peer faulted, self healthy: take over
// R2: Link seen then timed out: take over
// R3: Switch positions disagree: take over
// R4: Forced online command throws the switches
// R5: Offline mute enabled mutes offline transmit
// R6: Redundancy bias tee is inverse of mute
// R7: Direct bias tee writes rejected, mode error
// R8: Offline mute matrix applies in mode 2
// R9: Online unit keeps user settings, bias per matrix
// R10: Offline mute and amplifier forced per selection
// R11: Offline bias tee and LNB forced per selection
// R12: Offline unit polls and copies peer settings
// R13: Follow takes peer value, forced ignores it
// R14: LNB selection decodes to voltage and tone
// R15: Online command reports status, write forces active
// R16: Switch mode selects redundancy or standalone
// R17: Autorecover picks latched or self-clearing faults
// R18: Attenuation trim is local, never copied
// R19: Online when transmit switch routes to antenna
// R20: Standalone always online, switches ignored
// R21: Only the offline unit drives the switches
// R22: Peer answers polls over the link
// R23: Faulted offline unit never drives switches
//
// Chosen here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module rsc_top #(
  parameter int unsigned POLL_CYCLES    = rsc_pkg::POLL_CYCLES,
  parameter int unsigned TIMEOUT_CYCLES = rsc_pkg::TIMEOUT_CYCLES
) (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  input  wire logic        local_fault_i,
  input  wire logic        tx_pos_i,
  input  wire logic        rx_pos_i,
  input  wire logic        peer_resp_i,
  input  wire logic        peer_fault_i,
  input  wire logic        peer_amp_i,
  input  wire logic        peer_mute_i,
  input  wire logic        peer_aux_i,
  input  wire logic [2:0]  peer_lnb_i,
  output logic             peer_poll_o,
  output logic             wg_throw_o,
  output logic             online_o,
  output logic             tx_mute_o,
  output logic             amplifier_on_o,
  output logic             aux_mute_o,
  output logic             rx_bias_tee_switch_o,
  output logic             lnb_en_o,
  output logic             lnb_18v_o,
  output logic             lnb_tone_o,
  output logic [7:0]       attenuation_trim_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]        swm;
    logic [2:0]        ofl;
    logic              arec;
    logic              amplifier_on;
    logic              mute;
    logic              aux;
    logic [2:0]        lnb;
    logic              bt;
    logic [7:0]        trim;
    logic              force_on;
    logic              fault;
    logic              mode_err;
    rsc_pkg::rsc_link_t link;
    logic [31:0]       link_cnt;
    logic [31:0]       poll_cnt;
    logic              p_fault;
    logic              p_amp;
    logic              p_mute;
    logic              p_aux;
    logic [2:0]        p_lnb;
    logic              a_valid;
    logic              a_write;
    logic [7:0]        a_addr;
    logic [31:0]       rdata;
    logic              online;
    logic              throw;
    logic              poll;
    logic              o_mute;
    logic              o_amp;
    logic              o_aux;
    logic              o_bt;
    logic [2:0]        o_lnb;
  } rsc_state_t;

  rsc_state_t r;
  rsc_state_t r_nxt;

  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  // R14: selection to {enable, 18V, tone}
  function automatic logic [2:0] lnb_decode(input logic [2:0] sel);
    case (sel)
      3'h1:    lnb_decode = 3'h6;
      3'h2:    lnb_decode = 3'h7;
      3'h3:    lnb_decode = 3'h4;
      3'h4:    lnb_decode = 3'h5;
      default: lnb_decode = 3'h0;
    endcase
  endfunction

  // Forced offline values {mute_f, amp_f, lnb_f, bt_forced, bt_val}
  function automatic logic [4:0] ofl_force(input logic [2:0] ofl);
    case (ofl)
      3'h1:    ofl_force = 5'h12;
      3'h2:    ofl_force = 5'h02;
      3'h3:    ofl_force = 5'h13;
      3'h4:    ofl_force = 5'h06;
      3'h5:    ofl_force = 5'h17;
      3'h6:    ofl_force = 5'h1B;
      3'h7:    ofl_force = 5'h1F;
      default: ofl_force = 5'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic       redund;
  logic       mismatch;
  logic       online;
  logic [4:0] frc;
  logic       wr_ctrl;
  logic       wr_trim;
  logic       wr_stat;
  logic       resp_ok;

  always_comb begin
    r_nxt    = r;
    // R16: mode zero is standalone
    redund   = (r.swm != rsc_pkg::SWM_STANDALONE);
    // R19: R20: online from the transmit switch only in redundancy
    online   = redund ? tx_pos_i : 1'b1;
    mismatch = (r.swm == rsc_pkg::SWM_TXRX) && (tx_pos_i != rx_pos_i);
    frc      = ofl_force(r.ofl);
    resp_ok  = redund && peer_resp_i;
    wr_ctrl  = r.a_valid && r.a_write && (r.a_addr == rsc_pkg::OFS_CTRL);
    wr_trim  = r.a_valid && r.a_write && (r.a_addr == rsc_pkg::OFS_TRIM);
    wr_stat  = r.a_valid && r.a_write && (r.a_addr == rsc_pkg::OFS_STATUS);

    // AHB-Lite: zero wait states, always OKAY
    r_nxt.a_valid = hsel_i && htrans_i[1] && hready_i;
    r_nxt.a_write = hwrite_i;
    r_nxt.a_addr  = haddr_i[7:0];
    r_nxt.rdata   = 32'h0000_0000;
    if (hsel_i && htrans_i[1] && hready_i && !hwrite_i) begin
      case (haddr_i[7:0])
        rsc_pkg::OFS_CTRL: begin
          r_nxt.rdata[rsc_pkg::CTL_SWM_LSB +: 2] = r.swm;
          r_nxt.rdata[rsc_pkg::CTL_OFL_LSB +: 3] = r.ofl;
          r_nxt.rdata[rsc_pkg::CTL_AREC]         = r.arec;
          r_nxt.rdata[rsc_pkg::CTL_AMP]          = r.amplifier_on;
          r_nxt.rdata[rsc_pkg::CTL_MUTE]         = r.mute;
          r_nxt.rdata[rsc_pkg::CTL_AUX]          = r.aux;
          r_nxt.rdata[rsc_pkg::CTL_LNB_LSB +: 3] = r.lnb;
          r_nxt.rdata[rsc_pkg::CTL_BT]           = r.bt;
          r_nxt.rdata[rsc_pkg::CTL_FORCE]        = r.force_on;
        end
        rsc_pkg::OFS_TRIM:   r_nxt.rdata[7:0] = r.trim;
        rsc_pkg::OFS_STATUS: begin
          // R15: online status readback
          r_nxt.rdata[rsc_pkg::STA_ONLINE]    = r.online;
          r_nxt.rdata[rsc_pkg::STA_LINK_UP]   = (r.link == rsc_pkg::RSC_LINK_UP);
          r_nxt.rdata[rsc_pkg::STA_LINK_LOST] = (r.link == rsc_pkg::RSC_LINK_LOST);
          r_nxt.rdata[rsc_pkg::STA_FAULT]     = r.fault;
          r_nxt.rdata[rsc_pkg::STA_MODE_ERR]  = r.mode_err;
          r_nxt.rdata[rsc_pkg::STA_MISMATCH]  = mismatch;
          r_nxt.rdata[rsc_pkg::STA_THROW]     = r.throw;
          r_nxt.rdata[rsc_pkg::STA_PEER_FLT]  = r.p_fault;
        end
        rsc_pkg::OFS_OUTS: r_nxt.rdata[6:0] = {r.o_lnb, r.o_bt, r.o_aux, r.o_amp, r.o_mute};
        default: r_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // Register writes
    if (wr_ctrl) begin
      r_nxt.swm  = hwdata_i[rsc_pkg::CTL_SWM_LSB +: 2];
      r_nxt.ofl  = hwdata_i[rsc_pkg::CTL_OFL_LSB +: 3];
      r_nxt.arec = hwdata_i[rsc_pkg::CTL_AREC];
      r_nxt.amplifier_on  = hwdata_i[rsc_pkg::CTL_AMP];
      r_nxt.mute = hwdata_i[rsc_pkg::CTL_MUTE];
      r_nxt.aux  = hwdata_i[rsc_pkg::CTL_AUX];
      r_nxt.lnb  = hwdata_i[rsc_pkg::CTL_LNB_LSB +: 3];
      // R7: bias tee locked in redundancy mode
      if (redund && (hwdata_i[rsc_pkg::CTL_BT] != r.bt)) begin
        r_nxt.mode_err = 1'b1;
      end else begin
        r_nxt.bt = hwdata_i[rsc_pkg::CTL_BT];
      end
      // R4: R15: writing one forces the unit active
      r_nxt.force_on = r.force_on | hwdata_i[rsc_pkg::CTL_FORCE];
    end
    // R18: trim is local only
    r_nxt.trim = wr_trim ? hwdata_i[7:0] : r.trim;
    r_nxt.mode_err = r_nxt.mode_err && !(wr_stat && hwdata_i[rsc_pkg::STA_MODE_ERR]);
    // Force request retires once online
    r_nxt.force_on = r_nxt.force_on && !online;

    // R17: latched or self-clearing fault, set wins
    if (r.arec) begin
      r_nxt.fault = local_fault_i;
    end else if (local_fault_i) begin
      r_nxt.fault = 1'b1;
    end else if (wr_stat && hwdata_i[rsc_pkg::STA_FAULT]) begin
      r_nxt.fault = 1'b0;
    end

    // R12: periodic poll of the peer
    r_nxt.poll = 1'b0;
    if (!redund) begin
      r_nxt.poll_cnt = 32'h0000_0000;
    end else if (r.poll_cnt >= POLL_CYCLES - 1) begin
      r_nxt.poll_cnt = 32'h0000_0000;
      r_nxt.poll     = 1'b1;
    end else begin
      r_nxt.poll_cnt = r.poll_cnt + 32'h0000_0001;
    end

    // R22: R13: answers refresh the followed copies
    if (resp_ok) begin
      r_nxt.p_fault = peer_fault_i;
      r_nxt.p_amp   = peer_amp_i;
      r_nxt.p_mute  = peer_mute_i;
      r_nxt.p_aux   = peer_aux_i;
      r_nxt.p_lnb   = peer_lnb_i;
    end

    // R2: link supervision
    r_nxt.link_cnt = resp_ok ? 32'h0000_0000 : r.link_cnt + 32'h0000_0001;
    case (r.link)
      rsc_pkg::RSC_LINK_NONE, rsc_pkg::RSC_LINK_LOST: begin
        r_nxt.link_cnt = 32'h0000_0000;
        if (resp_ok) begin
          r_nxt.link = rsc_pkg::RSC_LINK_UP;
        end
      end
      rsc_pkg::RSC_LINK_UP: begin
        if (!resp_ok && (r.link_cnt >= TIMEOUT_CYCLES - 1)) begin
          r_nxt.link = rsc_pkg::RSC_LINK_LOST;
        end
      end
      default: r_nxt.link = rsc_pkg::RSC_LINK_NONE;
    endcase
    if (!redund) begin
      r_nxt.link = rsc_pkg::RSC_LINK_NONE;
    end

    // R1: R3: R4: R21: R23: only a healthy offline unit throws
    r_nxt.online = online;
    r_nxt.throw  = redund && !online && !r.fault &&
                   ((r.p_fault && (r.link == rsc_pkg::RSC_LINK_UP)) ||
                    (r.link == rsc_pkg::RSC_LINK_LOST) || mismatch || r.force_on);

    // R9: online unit keeps user settings
    r_nxt.o_mute = r.mute;
    r_nxt.o_amp  = r.amplifier_on;
    r_nxt.o_aux  = r.aux;
    r_nxt.o_lnb  = lnb_decode(r.lnb);
    r_nxt.o_bt   = r.bt;
    if (redund) begin
      // R6: bias tee is inverse of mute
      r_nxt.o_bt = !r.mute;
      if (r.swm == rsc_pkg::SWM_TXRX && r.ofl != 3'h0) begin
        r_nxt.o_bt = (r.ofl != 3'h2);
      end
    end
    if (redund && !online) begin
      // R13: offline follows the peer copies
      r_nxt.o_mute = r.p_mute;
      r_nxt.o_amp  = r.p_amp;
      r_nxt.o_aux  = r.p_aux;
      r_nxt.o_lnb  = lnb_decode(r.p_lnb);
      r_nxt.o_bt   = !r.p_mute;
      if (r.swm == rsc_pkg::SWM_TXRX) begin
        // R8: R10: R11: forcing matrix
        r_nxt.o_mute = r_nxt.o_mute | frc[4];
        r_nxt.o_amp  = r_nxt.o_amp & !frc[3];
        r_nxt.o_bt   = frc[1] ? frc[0] : !r_nxt.o_mute;
        r_nxt.o_lnb  = frc[2] ? 3'h0 : r_nxt.o_lnb;
      end else if (r.ofl != 3'h0) begin
        // R5: offline mute in transmit-only mode
        r_nxt.o_mute = 1'b1;
        r_nxt.o_bt   = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r          <= '0;
      r.swm      <= rsc_pkg::RST_SWM;
      r.ofl      <= rsc_pkg::RST_OFL;
      r.lnb      <= rsc_pkg::RST_LNB;
      r.trim     <= rsc_pkg::RST_TRIM;
      r.link     <= rsc_pkg::RSC_LINK_NONE;
      r.online   <= 1'b1;
      r.o_bt     <= 1'b0;
    end else begin
      r <= r_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic hreadyout_r;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hreadyout_r <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
    end
  end

  assign hreadyout_o          = hreadyout_r;
  assign hresp_o              = 1'b0;
  assign hrdata_o             = r.rdata;
  assign peer_poll_o          = r.poll;
  assign wg_throw_o           = r.throw;
  assign online_o             = r.online;
  assign tx_mute_o            = r.o_mute;
  assign amplifier_on_o       = r.o_amp;
  assign aux_mute_o           = r.o_aux;
  assign rx_bias_tee_switch_o = r.o_bt;
  assign lnb_en_o             = r.o_lnb[2];
  assign lnb_18v_o            = r.o_lnb[1];
  assign lnb_tone_o           = r.o_lnb[0];
  assign attenuation_trim_o   = r.trim;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence ctrl_addr_s;
    hsel_i && htrans_i[1] && hready_i && hwrite_i && (haddr_i[7:0] == rsc_pkg::OFS_CTRL)
      && (r.swm != rsc_pkg::SWM_STANDALONE);
  endsequence
  sequence bt_change_s;
    (hwdata_i[rsc_pkg::CTL_BT] != r.bt);
  endsequence

  a_bias_reject: assert property (ctrl_addr_s ##1 bt_change_s |=> r.mode_err && $stable(r.bt)) // R7
    else $error("bias tee write not rejected");
  a_peer_takeover: assert property ((r.swm != 2'h0) && (r.link == rsc_pkg::RSC_LINK_UP) // R1
    && r.p_fault && !tx_pos_i && !r.fault |=> wg_throw_o)
    else $error("no takeover on peer fault");
  a_link_takeover: assert property ((r.swm != 2'h0) && (r.link == rsc_pkg::RSC_LINK_LOST) // R2
    && !tx_pos_i && !r.fault |=> wg_throw_o)
    else $error("no takeover on link loss");
  a_mismatch_throw: assert property ((r.swm == 2'h2) && (tx_pos_i != rx_pos_i) // R3
    && !tx_pos_i && !r.fault |=> wg_throw_o)
    else $error("no takeover on switch mismatch");
  a_fault_blocks: assert property (r.fault || tx_pos_i || (r.swm == 2'h0) |=> !wg_throw_o) // R23
    else $error("switch driven while not allowed");
  a_standalone_online: assert property ((r.swm == 2'h0) |=> online_o) // R20
    else $error("standalone unit not online");
  a_online_tracks: assert property ((r.swm != 2'h0) |=> online_o == $past(tx_pos_i)) // R19
    else $error("online status not from switch");
  a_offline_mute: assert property ((r.swm == 2'h2) && !tx_pos_i // R10
    && (r.ofl inside {3'h1, 3'h3, 3'h5, 3'h6, 3'h7}) |=> tx_mute_o)
    else $error("offline mute not forced");
  a_lnb_forced: assert property ((r.swm == 2'h2) && !tx_pos_i // R11
    && (r.ofl inside {3'h4, 3'h5, 3'h7}) |=> !lnb_en_o)
    else $error("offline lnb not forced off");
  a_online_bias: assert property ((r.swm == 2'h2) && tx_pos_i && (r.ofl == 3'h2) // R9
    |=> !rx_bias_tee_switch_o)
    else $error("online bias tee wrong");
  a_link_timeout: assert property ((r.link == rsc_pkg::RSC_LINK_UP) && !peer_resp_i // R2
    && (r.swm != 2'h0) && (r.link_cnt == TIMEOUT_CYCLES - 1) |=> r.link == rsc_pkg::RSC_LINK_LOST)
    else $error("link timeout missed");
  a_fault_recover: assert property (r.arec && !local_fault_i |=> !r.fault) // R17
    else $error("fault did not recover");

endmodule

/* test/rsc_peer_model.sv */
// Peer unit and waveguide switch model
`timescale 1ns/1ns
module rsc_peer_model (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       peer_poll_i,
  input  wire logic       wg_throw_i,
  input  wire logic       silent_i,
  input  wire logic       slow_i,
  input  wire logic       home_i,
  input  wire logic       mis_i,
  input  wire logic [6:0] set_i,
  output logic            peer_resp_o,
  output logic [6:0]      peer_set_o,
  output logic            tx_pos_o,
  output logic            rx_pos_o
);
  logic [3:0] dly;
  logic [1:0] hold;
  logic       pos;
  // ------------------------------------------------------------
  // Poll answer and switch motion
  // ------------------------------------------------------------
  // answer each poll unless silent
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dly <= 4'h0;
      peer_resp_o <= 1'b0;
      hold <= 2'h0;
      pos <= 1'b0;
    end else begin
      if (peer_poll_i && !silent_i) begin
        dly <= slow_i ? 4'h6 : 4'h1;
      end else if (dly != 4'h0) begin
        dly <= dly - 4'h1;
      end
      peer_resp_o <= (dly == 4'h1);
      if (home_i || !wg_throw_i) begin
        hold <= 2'h0;
      end else if (hold != 2'h3) begin
        hold <= hold + 2'h1;
      end
      if (home_i) begin
        pos <= 1'b0;
      end else if (hold == 2'h3) begin
        pos <= 1'b1;
      end
    end
  end
  // Data outside an answer is not valid
  assign peer_set_o = peer_resp_o ? set_i : ~set_i;
  assign tx_pos_o   = pos;
  assign rx_pos_o   = pos ^ mis_i;
endmodule

/* test/testbench.sv */
// Self-checking bench for the redundancy switchover control block
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin \
  n_compared++; \
  if ((gt) !== (ex)) begin \
    err_total++; \
    $display("mismatch %s exp %0h got %0h", nm, ex, gt); \
  end \
end
module testbench;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic        lflt    = 1'b0;
  logic        silent  = 1'b0;
  logic        slow    = 1'b0;
  logic        home    = 1'b1;
  logic        mis     = 1'b0;
  logic [6:0]  pset    = 7'h0;
  logic [6:0]  pdat;
  logic        hreadyout_o, hresp_o, peer_resp, peer_poll_o, wg_throw_o, online_o;
  logic        tx_pos, rx_pos, tx_mute_o, amplifier_on_o, aux_mute_o, rx_bias_tee_switch_o;
  logic        lnb_en_o, lnb_18v_o, lnb_tone_o;
  logic [31:0] hrdata_o, q;
  logic [7:0]  attenuation_trim_o;
  logic [6:0]  outs, p;
  logic [31:0] r;
  int          err_total  = 0;
  int          n_compared = 0;
  assign outs = {tx_mute_o, amplifier_on_o, aux_mute_o, rx_bias_tee_switch_o,
                 lnb_en_o, lnb_18v_o, lnb_tone_o};
  always #50 clock_i = ~clock_i;
  rsc_top #(.POLL_CYCLES(20), .TIMEOUT_CYCLES(60)) uut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .hrdata_o(hrdata_o), .local_fault_i(lflt), .tx_pos_i(tx_pos), .rx_pos_i(rx_pos),
    .peer_resp_i(peer_resp), .peer_fault_i(pdat[0]), .peer_amp_i(pdat[1]),
    .peer_mute_i(pdat[2]), .peer_aux_i(pdat[3]), .peer_lnb_i(pdat[6:4]),
    .peer_poll_o(peer_poll_o), .wg_throw_o(wg_throw_o), .online_o(online_o),
    .tx_mute_o(tx_mute_o), .amplifier_on_o(amplifier_on_o), .aux_mute_o(aux_mute_o),
    .rx_bias_tee_switch_o(rx_bias_tee_switch_o), .lnb_en_o(lnb_en_o),
    .lnb_18v_o(lnb_18v_o), .lnb_tone_o(lnb_tone_o),
    .attenuation_trim_o(attenuation_trim_o));
  rsc_peer_model peer (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .peer_poll_i(peer_poll_o),
    .wg_throw_i(wg_throw_o), .silent_i(silent), .slow_i(slow), .home_i(home),
    .mis_i(mis), .set_i(pset), .peer_resp_o(peer_resp), .peer_set_o(pdat),
    .tx_pos_o(tx_pos), .rx_pos_o(rx_pos));
  // ------------------------------------------------------------
  // Tasks and expectations
  // ------------------------------------------------------------
  task automatic stop_test();
    if (err_total == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge clock_i);
    while (hreadyout_o !== 1'b1) begin
      k++;
      if (k > 50) begin
        err_total++;
        stop_test();
      end
      @(posedge clock_i);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata_o;
  endtask
  task automatic wait_until(input int sel, input logic v);
    for (int k = 0; k < 300; k++) begin
      @(posedge clock_i);
      if ((sel == 0 ? wg_throw_o : online_o) === v) return;
    end
    err_total++;
    stop_test();
  endtask
  function automatic logic [31:0] ctl(input logic [1:0] swm, input logic [2:0] ofl,
      input logic [3:0] fl, input logic [2:0] l, input logic bt, input logic frc);
    return (32'(swm) << rsc_pkg::CTL_SWM_LSB) | (32'(ofl) << rsc_pkg::CTL_OFL_LSB) |
           (32'(fl) << rsc_pkg::CTL_AREC) | (32'(l) << rsc_pkg::CTL_LNB_LSB) |
           (32'(bt) << rsc_pkg::CTL_BT) | (32'(frc) << rsc_pkg::CTL_FORCE);
  endfunction
  function automatic logic [2:0] lnb(input logic [2:0] l);
    return {l != 3'h0, l == 3'h1 || l == 3'h2, l == 3'h2 || l == 3'h4};
  endfunction
  function automatic logic [6:0] exp_off(input logic [2:0] o, input logic [6:0] v);
    logic m, a, b;
    m = (o inside {1, 3, 5, 6, 7}) ? 1'b1 : v[2];
    a = (o >= 3'h6) ? 1'b0 : v[1];
    b = (o == 3'h0) ? !m : !(o inside {1, 2, 4});
    return {m, a, v[3], b, lnb((o inside {4, 5, 7}) ? 3'h0 : v[6:4])};
  endfunction
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(88745));
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    bus(1'b0, rsc_pkg::OFS_CTRL, 32'h0);
    `CHK("ctrl_rst", 32'h0, q)
    bus(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 32'h0, q)
    r = $urandom;
    bus(1'b1, rsc_pkg::OFS_TRIM, r);
    bus(1'b0, rsc_pkg::OFS_TRIM, 32'h0);
    `CHK("trim", {24'h0, r[7:0]}, q)
    `CHK("trim_o", r[7:0], attenuation_trim_o)
    for (int l = 0; l < 5; l++) begin
      r = $urandom;
      bus(1'b1, rsc_pkg::OFS_CTRL, ctl(2'h0, 3'h0, r[3:0], 3'(l), r[4], 1'b0));
      repeat (3) @(posedge clock_i);
      `CHK("standalone", {r[2], r[1], r[3], r[4], lnb(3'(l))}, outs)
      `CHK("sa_online", 1'b1, online_o)
      `CHK("sa_throw", 1'b0, wg_throw_o)
    end
    bus(1'b1, rsc_pkg::OFS_CTRL, ctl(2'h2, 3'h0, 4'h0, 3'h0, 1'b0, 1'b0));
    bus(1'b1, rsc_pkg::OFS_CTRL, ctl(2'h2, 3'h0, 4'h0, 3'h0, 1'b1, 1'b0));
    bus(1'b0, rsc_pkg::OFS_STATUS, 32'h0);
    `CHK("mode_err", 1'b1, q[rsc_pkg::STA_MODE_ERR])
    bus(1'b1, rsc_pkg::OFS_STATUS, 32'h10);
    for (int o = 0; o < 8; o++) begin
      p = {3'($urandom_range(4)), 3'($urandom), 1'b0};
      pset <= p;
      slow <= o[0];
      bus(1'b1, rsc_pkg::OFS_CTRL, ctl(2'h2, 3'(o), 4'h0, 3'h0, 1'b0, 1'b0));
      repeat (40) @(posedge clock_i);
      `CHK("offline", exp_off(3'(o), p), outs)
      `CHK("idle_throw", 1'b0, wg_throw_o)
    end
    bus(1'b1, rsc_pkg::OFS_CTRL, ctl(2'h1, 3'h1, 4'h0, 3'h0, 1'b0, 1'b0));
    repeat (40) @(posedge clock_i);
    `CHK("tx_only", {1'b1, p[1], p[3], 1'b0, lnb(p[6:4])}, outs)
    bus(1'b0, rsc_pkg::OFS_STATUS, 32'h0);
    `CHK("link_up", 1'b1, q[rsc_pkg::STA_LINK_UP])
    lflt <= 1'b1;
    pset <= 7'h01;
    home <= 1'b0;
    bus(1'b1, rsc_pkg::OFS_CTRL, ctl(2'h2, 3'h0, 4'h1, 3'h0, 1'b0, 1'b0));
    repeat (40) @(posedge clock_i);
    `CHK("flt_throw", 1'b0, wg_throw_o)
    lflt <= 1'b0;
    wait_until(0, 1'b1);
    wait_until(1, 1'b1);
    wait_until(0, 1'b0);
    for (int o = 0; o < 8; o++) begin
      r = $urandom;
      bus(1'b1, rsc_pkg::OFS_CTRL,
          ctl(2'h2, 3'(o), {r[3:1], 1'b1}, 3'(r[31:29] % 3'h5), 1'b0, 1'b0));
      repeat (3) @(posedge clock_i);
      `CHK("online", {r[2], r[1], r[3], (o == 0) ? !r[2] : (o != 2)}, outs[6:3])
      `CHK("on_lnb", lnb(3'(r[31:29] % 3'h5)), outs[2:0])
      `CHK("on_throw", 1'b0, wg_throw_o)
    end
    pset <= 7'h0;
    home <= 1'b1;
    wait_until(1, 1'b0);
    repeat (40) @(posedge clock_i);
    silent <= 1'b1;
    home <= 1'b0;
    wait_until(0, 1'b1);
    bus(1'b0, rsc_pkg::OFS_STATUS, 32'h0);
    `CHK("link_lost", 1'b1, q[rsc_pkg::STA_LINK_LOST])
    silent <= 1'b0;
    for (int s = 0; s < 2; s++) begin
      home <= 1'b1;
      bus(1'b1, rsc_pkg::OFS_CTRL, ctl(2'h0, 3'h0, 4'h1, 3'h0, 1'b0, 1'b0));
      bus(1'b1, rsc_pkg::OFS_CTRL, ctl(2'h2, 3'h0, 4'h1, 3'h0, 1'b0, 1'b0));
      wait_until(1, 1'b0);
      mis <= (s == 0);
      if (s == 1) bus(1'b1, rsc_pkg::OFS_CTRL, ctl(2'h2, 3'h0, 4'h1, 3'h0, 1'b0, 1'b1));
      wait_until(0, 1'b1);
      bus(1'b0, rsc_pkg::OFS_CTRL, 32'h0);
      if (s == 1) `CHK("force_pend", 1'b1, q[rsc_pkg::CTL_FORCE])
      home <= 1'b0;
      wait_until(1, 1'b1);
      mis <= 1'b0;
    end
    bus(1'b0, rsc_pkg::OFS_STATUS, 32'h0);
    `CHK("sta_online", 1'b1, q[rsc_pkg::STA_ONLINE])
    home <= 1'b1;
    bus(1'b1, rsc_pkg::OFS_CTRL, ctl(2'h0, 3'h0, 4'h1, 3'h0, 1'b0, 1'b0));
    repeat (10) @(posedge clock_i);
    `CHK("sa_pos0", 2'b10, {online_o, wg_throw_o})
    stop_test();
  end
endmodule
